/* File: rtl/microcore_setup_instr_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "setup_exec_defs.svh"

module microcore_setup_instr_exec
    import setup_exec_pkg::*;
#(
    parameter int AW = 10,
    parameter logic [1:0] OWN_CH = 2'h0,
    parameter logic OWN_CORE = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    // Indexed data RAM addressing
    input wire logic indexed_data_mode,
    input wire logic [AW-1:0] dram_addr_operand,
    output logic [AW-1:0] dram_addr,
    // Add/subtract and other ALU operations
    input wire logic alu_valid,
    input wire alu_op_type alu_op,
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    output logic [15:0] alu_result,
    output logic alu_overflow,
    // Configuration state
    output logic [5:0] index_base,
    output logic base_sel,
    output logic arith_mode_bit_hi,
    output logic arith_mode_bit_lo,
    output logic [5:0] converter_enable_flag
);

    localparam int NBLK = 6;

    // Other channel, for either setting of the exchange bit
    localparam logic [1:0] CH_NEXT = (OWN_CH == 2'h2) ? 2'h0 : OWN_CH + 2'h1;
    localparam logic [1:0] CH_PREV = (OWN_CH == 2'h0) ? 2'h2 : OWN_CH - 2'h1;

    function automatic logic op_match(input logic [15:0] w, input logic [15:0] pat,
                                      input logic [15:0] msk);
        op_match = ((w & msk) == pat);
    endfunction : op_match

    // Block index is channel * 2 + core
    function automatic logic [2:0] block_index(input measure_block_target_type tgt,
                                               input logic xcfg);
        logic [1:0] ch;
        logic core;
        core = OWN_CORE ^ tgt[0];
        if (tgt[1]) begin
            ch = xcfg ? CH_PREV : CH_NEXT;
        end else begin
            ch = OWN_CH;
        end
        block_index = {ch, core};
    endfunction : block_index

    // Registers
    logic [5:0] index_base_q, index_base_d;
    logic base_sel_q, base_sel_d;
    arith_mode_type arith_mode_q, arith_mode_d;
    wire logic [NBLK-1:0] conv_q;
    logic [5:0] rights_q;
    logic xcfg_q;
    logic [15:0] immed_q;
    logic [AW-1:0] dram_addr_q;
    logic [15:0] alu_result_q;
    logic alu_overflow_q;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    // Instruction decode
    wire logic exec = ce && instr_valid;
    wire logic is_load_base = op_match(instr_word, `OPC_LOAD_BASE, `MSK_LOAD_BASE);
    wire logic is_sel_base = op_match(instr_word, `OPC_SEL_BASE, `MSK_SEL_BASE);
    wire logic is_conv_mode = op_match(instr_word, `OPC_CONV_MODE, `MSK_CONV_MODE);
    wire logic is_arith_mode = op_match(instr_word, `OPC_ARITH_MODE, `MSK_ARITH_MODE);
    wire logic [5:0] base_field = instr_word[`BASE_FIELD_HI:`BASE_FIELD_LO];
    wire logic conv_field = instr_word[`CONV_FLAG_BIT];
    wire measure_block_target_type measure_block_target =
        measure_block_target_type'(instr_word[`FIELD2_HI:`FIELD2_LO]);
    wire arith_mode_type arith_mode_select =
        arith_mode_type'(instr_word[`FIELD2_HI:`FIELD2_LO]);
    wire logic [2:0] tgt_idx = block_index(measure_block_target, xcfg_q);
    wire logic tgt_allowed = rights_q[tgt_idx];

    assign index_base_d = (exec && is_load_base) ? base_field : index_base_q;
    assign base_sel_d = (exec && is_sel_base) ? instr_word[`SEL_BASE_BIT] : base_sel_q;
    assign arith_mode_d = (exec && is_arith_mode) ? arith_mode_select : arith_mode_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_base_q <= `RST_INDEX_BASE;
            base_sel_q <= `RST_BASE_SEL;
            arith_mode_q <= arith_mode_type'(`RST_ARITH_MODE);
        end else if (ce) begin
            index_base_q <= index_base_d;
            base_sel_q <= base_sel_d;
            arith_mode_q <= arith_mode_d;
        end
    end

    // Converter mode flag per measurement block
    genvar gi;
    generate
        for (gi = 0; gi < NBLK; gi++) begin : g_blk
            wire logic hit = exec && is_conv_mode && tgt_allowed && (tgt_idx == 3'(gi));
            logic flag_q;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flag_q <= 1'b0;
                end else if (hit) begin
                    flag_q <= conv_field;
                end
            end
            assign conv_q[gi] = flag_q;
        end
    endgenerate

    // Indexed data RAM address
    wire logic [AW-1:0] base_val = base_sel_q ? immed_q[AW-1:0] : AW'(index_base_q);
    wire logic [AW-1:0] index_sum = dram_addr_operand + base_val;
    wire logic [AW-1:0] dram_addr_d = indexed_data_mode ? index_sum : dram_addr_operand;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dram_addr_q <= '0;
        end else if (ce) begin
            dram_addr_q <= dram_addr_d;
        end
    end

    // Arithmetic unit under the selected mode
    logic [15:0] alu_res_w;
    logic alu_ovf_w;

    arith_addsub u_arith (
        .mode(arith_mode_q),
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .result(alu_res_w),
        .overflow(alu_ovf_w)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alu_result_q <= 16'h0000;
            alu_overflow_q <= 1'b0;
        end else if (ce && alu_valid) begin
            alu_result_q <= alu_res_w;
            alu_overflow_q <= alu_ovf_w;
        end
    end

    // Bus slave: address phase capture
    wire logic addr_take = hsel && htrans[1] && hready;
    wire logic [31:0] wd_addr = wr_addr_q;
    wire logic wr_rights = wr_pend_q && (wd_addr == `OFS_RIGHTS);
    wire logic wr_xcfg = wr_pend_q && (wd_addr == `OFS_XCFG);
    wire logic wr_immed = wr_pend_q && (wd_addr == `OFS_IMMED);

    wire logic [31:0] status_word = {17'h00000, conv_q,
                                     arith_mode_q, base_sel_q, index_base_q};
    logic [31:0] rd_mux;

    always_comb begin
        if (haddr == `OFS_RIGHTS) begin
            rd_mux = {26'h0000000, rights_q};
        end else if (haddr == `OFS_XCFG) begin
            rd_mux = {31'h00000000, xcfg_q};
        end else if (haddr == `OFS_IMMED) begin
            rd_mux = {16'h0000, immed_q};
        end else if (haddr == `OFS_STATUS) begin
            rd_mux = status_word;
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else if (ce) begin
            hreadyout_q <= 1'b1;
            // Response is always OKAY
            hresp_q <= 1'b0;
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                wr_addr_q <= haddr;
            end
            if (addr_take && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Software writable configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rights_q <= `RST_RIGHTS;
            xcfg_q <= `RST_XCFG;
            immed_q <= `RST_IMMED;
        end else if (ce) begin
            if (wr_rights) begin
                rights_q <= hwdata[5:0];
            end
            if (wr_xcfg) begin
                xcfg_q <= hwdata[0];
            end
            if (wr_immed) begin
                immed_q <= hwdata[15:0];
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign dram_addr = dram_addr_q;
    assign alu_result = alu_result_q;
    assign alu_overflow = alu_overflow_q;
    assign index_base = index_base_q;
    assign base_sel = base_sel_q;
    assign arith_mode_bit_hi = arith_mode_q[1];
    assign arith_mode_bit_lo = arith_mode_q[0];
    assign converter_enable_flag = conv_q;

endmodule : microcore_setup_instr_exec
`default_nettype wire

/* File: rtl/setup_exec_defs.svh */
`ifndef SETUP_EXEC_DEFS_SVH
`define SETUP_EXEC_DEFS_SVH

// Instruction opcodes and masks
`define OPC_LOAD_BASE 16'h3400
`define MSK_LOAD_BASE 16'hffc0
`define OPC_SEL_BASE 16'h360a
`define MSK_SEL_BASE 16'hfffe
`define OPC_CONV_MODE 16'h3568
`define MSK_CONV_MODE 16'hfff8
`define OPC_ARITH_MODE 16'h357c
`define MSK_ARITH_MODE 16'hfffc

// Instruction field positions
`define BASE_FIELD_HI 5
`define BASE_FIELD_LO 0
`define SEL_BASE_BIT 0
`define CONV_FLAG_BIT 2
`define FIELD2_HI 1
`define FIELD2_LO 0

// Register byte offsets
`define OFS_RIGHTS 32'h0000_0000
`define OFS_XCFG 32'h0000_0004
`define OFS_IMMED 32'h0000_0008
`define OFS_STATUS 32'h0000_000c

// Status register layout
`define ST_BASE_HI 5
`define ST_BASE_LO 0
`define ST_SEL_BIT 6
`define ST_MODE_HI 8
`define ST_MODE_LO 7
`define ST_CONV_HI 14
`define ST_CONV_LO 9

// Reset values
`define RST_INDEX_BASE 6'h00
`define RST_BASE_SEL 1'b0
`define RST_ARITH_MODE 2'h2
`define RST_RIGHTS 6'h00
`define RST_XCFG 1'b0
`define RST_IMMED 16'h0000

// Saturation limits
`define SAT_SMAX 16'h7fff
`define SAT_SMIN 16'h8000
`define SAT_UMAX 16'hffff
`define SAT_UMIN 16'h0000

`endif

/* File: rtl/setup_exec_pkg.sv */
package setup_exec_pkg;

    typedef enum logic [1:0] {
        signed_wrap_mode = 2'h0,
        signed_clamp_mode = 2'h1,
        unsigned_wrap_mode = 2'h2,
        unsigned_clamp_mode = 2'h3
    } arith_mode_type;

    typedef enum logic [1:0] {
        alu_add = 2'h0,
        alu_sub = 2'h1,
        alu_xor = 2'h2,
        alu_shl = 2'h3
    } alu_op_type;

    typedef enum logic [1:0] {
        tgt_own_core_own_ch = 2'h0,
        tgt_other_core_own_ch = 2'h1,
        tgt_own_core_other_ch = 2'h2,
        tgt_other_core_other_ch = 2'h3
    } measure_block_target_type;

endpackage : setup_exec_pkg

/* File: rtl/arith_addsub.sv */
`timescale 1ns/1ps
`default_nettype none
`include "setup_exec_defs.svh"

module arith_addsub
    import setup_exec_pkg::*;
(
    input wire arith_mode_type mode,
    input wire alu_op_type op,
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    output logic [15:0] result,
    output logic overflow
);

    wire logic is_sub = (op == alu_sub);
    wire logic [16:0] b_ext = {1'b0, b};
    wire logic [16:0] raw = is_sub ? ({1'b0, a} - b_ext) : ({1'b0, a} + b_ext);
    wire logic is_signed = (mode == signed_wrap_mode) || (mode == signed_clamp_mode);
    wire logic is_clamp = (mode == signed_clamp_mode) || (mode == unsigned_clamp_mode);
    // Signed overflow: operands agree in sign (b inverted for subtract), result differs
    wire logic s_ovf = ((a[15] == (b[15] ^ is_sub)) && (raw[15] != a[15]));
    wire logic u_ovf = raw[16];
    wire logic addsub_ovf = is_signed ? s_ovf : u_ovf;
    wire logic [15:0] s_limit = a[15] ? `SAT_SMIN : `SAT_SMAX;
    wire logic [15:0] u_limit = is_sub ? `SAT_UMIN : `SAT_UMAX;
    wire logic [15:0] sat_val = is_signed ? s_limit : u_limit;
    wire logic [15:0] addsub_res = (is_clamp && addsub_ovf) ? sat_val : raw[15:0];
    wire logic is_addsub = (op == alu_add) || is_sub;

    // Mode touches add and subtract only
    assign result = is_addsub ? addsub_res :
                    (op == alu_xor) ? (a ^ b) : {a[14:0], 1'b0};
    assign overflow = is_addsub && addsub_ovf;

endmodule : arith_addsub
`default_nettype wire

/* File: test/setup_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module setup_exec_properties
    import setup_exec_pkg::*;
#(
    parameter int AW = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic indexed_data_mode,
    input wire logic [AW-1:0] dram_addr_operand,
    input wire logic [AW-1:0] dram_addr,
    input wire logic base_sel,
    input wire logic [5:0] index_base,
    input wire logic alu_valid,
    input wire alu_op_type alu_op,
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    input wire logic [15:0] alu_result,
    input wire logic alu_overflow,
    input wire logic arith_mode_bit_hi,
    input wire logic arith_mode_bit_lo,
    input wire logic [5:0] converter_enable_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic ld = ce && instr_valid && (instr_word & 16'hffc0) == 16'h3400;
    wire logic am = ce && instr_valid && (instr_word & 16'hfffc) == 16'h357c;
    wire logic cv = ce && instr_valid && (instr_word & 16'hfff8) == 16'h3568;
    wire logic [1:0] md = {arith_mode_bit_hi, arith_mode_bit_lo};
    base_load_a: assert property (ld |=> index_base == $past(instr_word[5:0]))
        else $error("base not loaded");
    index_addr_a: assert property (ce && indexed_data_mode && !base_sel |=>
        dram_addr == AW'($past(dram_addr_operand) + $past(index_base)))
        else $error("indexed address wrong");
    mode_store_a: assert property (am |=> md == $past(instr_word[1:0]))
        else $error("mode not stored");
    reset_state_a: assert property ($rose(hresetn) |-> md == 2'h2 &&
        converter_enable_flag == 6'h00)
        else $error("reset state wrong");
    conv_only_a: assert property (!cv |=> $stable(converter_enable_flag))
        else $error("flags moved");
    conv_one_a: assert property (cv |=>
        $countones(converter_enable_flag ^ $past(converter_enable_flag)) <= 1)
        else $error("several flags moved");
    alu_xor_a: assert property (ce && alu_valid && alu_op == alu_xor |=>
        alu_result == ($past(alu_a) ^ $past(alu_b)) && !alu_overflow)
        else $error("xor affected");
    uclamp_add_a: assert property (ce && alu_valid && alu_op == alu_add && md == 2'h3 &&
        17'(alu_a) + 17'(alu_b) > 17'h0ffff |=> alu_result == 16'hffff && alu_overflow)
        else $error("no unsigned clamp");
    cover property (cv && instr_word[2]);
    cover property (am ##1 alu_valid);
    cover property (ld ##2 indexed_data_mode);
endmodule : setup_exec_properties
bind microcore_setup_instr_exec setup_exec_properties #(.AW(AW)) props (.hclk, .hresetn, .ce,
    .instr_valid, .instr_word, .indexed_data_mode, .dram_addr_operand, .dram_addr, .base_sel,
    .index_base, .alu_valid, .alu_op, .alu_a, .alu_b, .alu_result, .alu_overflow,
    .arith_mode_bit_hi, .arith_mode_bit_lo, .converter_enable_flag);
`default_nettype wire

/* File: test/instr_source.sv */
`timescale 1ns/1ps
`default_nettype none
module instr_source (
    input wire logic clk,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
    end
    // Holds word over one edge; leaves valid up for back to back use
    task automatic issue(input logic [15:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk);
    endtask : issue
    // Released word is inverted so stale data cannot pass
    task automatic idle();
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        #1;
    endtask : idle
    task automatic conv(input logic on, input logic [1:0] tgt);
        issue({13'h06ad, on, tgt});
        idle();
        repeat (2) @(posedge clk);
    endtask : conv
endmodule : instr_source
`default_nettype wire

/* File: test/microcore_setup_instr_exec_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module microcore_setup_instr_exec_bench;
    import setup_exec_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, alu_valid = 1'b0, ixm = 1'b0;
    logic ce = 1'b1, hsel = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [9:0] opnd = 10'h000;
    logic [15:0] alu_a = 16'h0, alu_b = 16'h0;
    logic [15:0] av [3] = '{16'h7ffd, 16'h0000, 16'hfffe};
    logic [15:0] bv [3] = '{16'h000f, 16'h0001, 16'h0003};
    alu_op_type alu_op = alu_add;
    wire logic rdy, resp, iv, bsel, mhi, mlo, ovf;
    wire logic [31:0] hrdata;
    wire logic [15:0] iw, res;
    wire logic [9:0] dra;
    wire logic [5:0] base, flags;
    int fails = 0, n_compared = 0;
    always #10 hclk = ~hclk;
    instr_source src (.clk(hclk), .instr_valid(iv), .instr_word(iw));
    microcore_setup_instr_exec dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(hrdata), .instr_valid(iv),
        .instr_word(iw), .indexed_data_mode(ixm), .dram_addr_operand(opnd), .dram_addr(dra),
        .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_result(res),
        .alu_overflow(ovf), .index_base(base), .base_sel(bsel), .arith_mode_bit_hi(mhi),
        .arith_mode_bit_lo(mlo), .converter_enable_flag(flags));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic alu(input alu_op_type op, input logic [15:0] a, b);
        alu_valid <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        @(posedge hclk);
        alu_valid <= 1'b0;
        #1;
    endtask : alu
    function automatic logic [16:0] exp_alu(input logic [1:0] m, input logic s,
        input logic [15:0] a, b);
        logic [16:0] u;
        logic ov;
        u = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        ov = m[1] ? u[16] : (a[15] ^ u[15]) & (s ? a[15] ^ b[15] : ~(a[15] ^ b[15]));
        if (ov && m == 2'h1) u[15:0] = a[15] ? 16'h8000 : 16'h7fff;
        if (ov && m == 2'h3) u[15:0] = s ? 16'h0000 : 16'hffff;
        return {ov, u[15:0]};
    endfunction : exp_alu
    task automatic t_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 32'h0c, 32'h0, rd);
        chk("status", rd, 32'h0000_0100);
        bus(1'b0, 32'h40, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        chk("resp", {31'h0, resp}, 32'h0);
        // Deselected write must not land
        hsel <= 1'b0;
        bus(1'b1, 32'h08, 32'h5a, rd);
        hsel <= 1'b1;
        bus(1'b0, 32'h08, 32'h0, rd);
        chk("deselected", rd, 32'h0);
    endtask : t_reset
    task automatic t_base();
        src.issue(16'h343f);
        src.issue(16'h3445);
        src.idle();
        chk("base", {26'h0, base}, 32'h3f);
        src.issue(16'h3410);
        src.idle();
        ixm <= 1'b1;
        opnd <= 10'h006;
        @(posedge hclk);
        #1;
        chk("index", {22'h0, dra}, 32'h16);
        bus(1'b1, 32'h08, 32'h25, rd);
        src.issue(16'h360b);
        src.idle();
        chk("sel", {31'h0, bsel}, 32'h1);
        @(posedge hclk);
        #1;
        chk("index imm", {22'h0, dra}, 32'h2b);
        src.issue(16'h360a);
        src.idle();
        chk("sel", {31'h0, bsel}, 32'h0);
        // Instruction with clock enable low is lost
        ce <= 1'b0;
        src.issue(16'h3401);
        src.idle();
        ce <= 1'b1;
        @(posedge hclk);
        #1;
        chk("frozen", {26'h0, base}, 32'h10);
    endtask : t_base
    task automatic t_conv();
        logic [5:0] e;
        e = 6'h00;
        src.conv(1'b1, 2'h0);
        chk("no right", {26'h0, flags}, 32'h0);
        bus(1'b1, 32'h00, 32'h3f, rd);
        for (int t = 0; t < 6; t++) begin
            // Last two pass with the other channel swapped
            if (t == 4) bus(1'b1, 32'h04, 32'h1, rd);
            src.conv(1'b1, 2'(t < 4 ? t : t - 2));
            e[t] = 1'b1;
            chk("flags", {26'h0, flags}, {26'h0, e});
        end
        bus(1'b1, 32'h00, 32'h3e, rd);
        src.conv(1'b0, 2'h0);
        src.conv(1'b0, 2'h1);
        bus(1'b0, 32'h0c, 32'h0, rd);
        chk("status", rd, {17'h0, 6'h3d, 2'h2, 1'b0, 6'h10});
    endtask : t_conv
    task automatic t_arith();
        logic [16:0] e;
        for (int m = 0; m < 4; m++) begin
            src.issue(16'h357c | 16'(m));
            src.idle();
            chk("mode", {30'h0, mhi, mlo}, 32'(m));
            for (int k = 0; k < 3; k++) begin
                alu(k == 1 ? alu_sub : alu_add, av[k], bv[k]);
                e = exp_alu(2'(m), k == 1, av[k], bv[k]);
                chk("alu", {15'h0, ovf, res}, {15'h0, e});
            end
            alu(alu_xor, 16'h5a5a, 16'hffff);
            chk("xor", {15'h0, ovf, res}, 32'h0000_a5a5);
            alu(alu_shl, 16'hc001, 16'h0000);
            chk("shl", {15'h0, ovf, res}, 32'h0000_8002);
        end
    endtask : t_arith
    initial begin
        t_reset();
        t_base();
        t_conv();
        t_arith();
        t_reset();
        close_out();
    end
    // Run needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge hclk);
        fails++;
        close_out();
    end
endmodule : microcore_setup_instr_exec_bench
`default_nettype wire
